/* core/spfr_pkg.sv */
// Constants, register map and types for the framed serial port
package spfr_pkg;
   //---------------------------------------------------------------
   // Register indices
   //---------------------------------------------------------------
   localparam int         ADDR_W   = 2;
   localparam logic [1:0] REG_STAT = 2'h0;
   localparam logic [1:0] REG_CON1 = 2'h1;
   localparam logic [1:0] REG_CON2 = 2'h2;
   localparam logic [1:0] REG_BUF  = 2'h3;

   //---------------------------------------------------------------
   // Field positions
   //---------------------------------------------------------------
   localparam int STAT_EN        = 15;
   localparam int STAT_SIDL      = 13;
   localparam int STAT_ROV       = 6;
   localparam int STAT_TBF       = 1;
   localparam int STAT_RBF       = 0;
   localparam int CON1_CLK_DIS   = 12;
   localparam int CON1_DOUT_DIS  = 11;
   localparam int CON1_WORD16    = 10;
   localparam int CON1_SAMPLE    = 9;
   localparam int CON1_EDGE      = 8;
   localparam int CON1_SEL_EN    = 7;
   localparam int CON1_POL       = 6;
   localparam int CON1_MASTER    = 5;
   localparam int CON1_SEC_LSB   = 2;
   localparam int CON1_PRI_LSB   = 0;
   localparam int CON2_FRAMED    = 15;
   localparam int CON2_SYNC_DIR  = 14;
   localparam int CON2_SYNC_POL  = 13;
   localparam int CON2_SYNC_EDGE = 1;

   //---------------------------------------------------------------
   // Reset values and write masks
   //---------------------------------------------------------------
   localparam logic [15:0] STAT_RST   = 16'h0000;
   localparam logic [15:0] CON1_RST   = 16'h0000;
   localparam logic [15:0] CON2_RST   = 16'h0000;
   localparam logic [15:0] CON1_WMASK = 16'h1fff;
   localparam logic [15:0] CON2_WMASK = 16'he002;

   //---------------------------------------------------------------
   // Bit clock prescalers and word lengths
   //---------------------------------------------------------------
   localparam logic [6:0] PRI_DIV [4] = '{7'h40, 7'h10, 7'h04, 7'h01};
   localparam logic [3:0] SEC_BASE    = 4'h8;
   localparam logic [4:0] BITS_BYTE   = 5'h08;
   localparam logic [4:0] BITS_WORD   = 5'h10;

   typedef enum logic [1:0] {
      SPFR_IDLE = 2'b01,
      SPFR_RUN  = 2'b10
   } spfr_state_t;
endpackage

/* core/spfr_port.sv */
// Framed synchronous serial port with holding buffers and register port
`timescale 1ns/1ps
module spfr_port (
   input  wire logic                        core_clk_i,   // 200 MHz clock
   input  wire logic                        reset_n_i,    // Sync reset, low
   input  wire logic                        idle_mode_i,  // Device idle mode
   input  wire logic [spfr_pkg::ADDR_W-1:0] reg_addr_i,   // Register index
   input  wire logic [15:0]                 reg_wdata_i,  // Write data
   input  wire logic                        reg_wr_i,     // Write strobe
   input  wire logic                        reg_rd_i,     // Read strobe
   output logic      [15:0]                 reg_rdata_o,  // Read data
   input  wire logic                        sck_i,        // Clock pin in
   output logic                             sck_o,        // Clock pin out
   output logic                             sck_oe_o,     // Clock pin drive
   input  wire logic                        sdi_i,        // Serial data in
   output logic                             sdo_o,        // Serial data out
   output logic                             sdo_oe_o,     // Data pin drive
   input  wire logic                        ss_i,         // Select/sync in
   output logic                             ss_o,         // Sync out
   output logic                             ss_oe_o       // Sync pin drive
);
   import spfr_pkg::*;

   //---------------------------------------------------------------
   // Registers and configuration
   //---------------------------------------------------------------
   logic        en_ff, sidl_ff, rov_ff, tbf_ff, rbf_ff;
   logic [15:0] con1_ff, con2_ff, txb_ff, rxb_ff, rdata_ff;
   logic        wr_buf, rd_buf;
   logic        master, w16, smp_end, clk_dis, dout_dis, clock_polarity, cke_eff;
   logic        framed, sync_dir, sync_pol, sync_edge, select_pin_enable_eff, pre;
   logic        halted;
   logic [4:0]  width, nbits;
   logic [10:0] div_w;

   assign wr_buf    = reg_wr_i && (reg_addr_i == REG_BUF);
   assign rd_buf    = reg_rd_i && (reg_addr_i == REG_BUF);
   assign master    = con1_ff[CON1_MASTER];
   assign w16       = con1_ff[CON1_WORD16];
   assign smp_end   = con1_ff[CON1_SAMPLE] & master;
   assign clk_dis   = con1_ff[CON1_CLK_DIS];
   assign dout_dis  = con1_ff[CON1_DOUT_DIS];
   assign clock_polarity       = con1_ff[CON1_POL];
   assign framed    = con2_ff[CON2_FRAMED];
   assign cke_eff   = con1_ff[CON1_EDGE] & ~framed;
   assign sync_dir  = con2_ff[CON2_SYNC_DIR];
   assign sync_pol  = con2_ff[CON2_SYNC_POL];
   assign sync_edge = con2_ff[CON2_SYNC_EDGE];
   assign select_pin_enable_eff  = con1_ff[CON1_SEL_EN] & ~framed & ~master;
   assign pre       = framed & ~sync_dir & ~sync_edge;
   assign halted    = sidl_ff & idle_mode_i;
   assign width     = w16 ? BITS_WORD : BITS_BYTE;
   assign nbits     = width + {4'h0, pre};
   assign div_w     = {4'h0, PRI_DIV[con1_ff[1:0]]}
                    * {7'h00, SEC_BASE - {1'b0, con1_ff[4:2]}};

   //---------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------
   logic [2:0] sync1_ff, sync2_ff;
   logic       sck_d_ff;
   logic       sck_s, sdi_s, ss_s, lead, trail, smp_edge, chg_edge;
   logic       ss_act, desel;

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         sck_d_ff <= 1'b0;
      end else begin
         sync1_ff <= {ss_i, sdi_i, sck_i};
         sync2_ff <= sync1_ff;
         sck_d_ff <= sync2_ff[0];
      end
   end

   assign sck_s    = sync2_ff[0];
   assign sdi_s    = sync2_ff[1];
   assign ss_s     = sync2_ff[2];
   assign lead     = (sck_d_ff == clock_polarity) && (sck_s != clock_polarity);
   assign trail    = (sck_d_ff != clock_polarity) && (sck_s == clock_polarity);
   assign smp_edge = cke_eff ? lead : trail;
   assign chg_edge = cke_eff ? trail : lead;
   assign ss_act   = (ss_s == sync_pol);
   assign desel    = select_pin_enable_eff & ss_s;

   //---------------------------------------------------------------
   // Shift engine
   //---------------------------------------------------------------
   spfr_state_t st_ff;
   logic [10:0] hcnt_ff;
   logic        phase_ff, samp_ff, dout_ff, sck_ff, sync_ff, armed_ff;
   logic [4:0]  bitn_ff;
   logic [15:0] sr_ff, done_word_ff, nw_m, nw_s;
   logic        done_ff, load_w, data_slot, last_slot, msb_sr, msb_tx;

   assign data_slot = !(pre && (bitn_ff == 5'h00));
   assign last_slot = (bitn_ff == nbits - 5'h01);
   assign msb_tx    = w16 ? txb_ff[15] : txb_ff[7];
   assign msb_sr    = w16 ? sr_ff[15] : sr_ff[7];
   assign nw_m      = {sr_ff[14:0], smp_end ? sdi_s : samp_ff};
   assign nw_s      = {sr_ff[14:0], sdi_s};

   always_comb begin
      load_w = 1'b0;
      if (en_ff && !halted && tbf_ff) begin
         if (master)
            load_w = (st_ff == SPFR_IDLE) && !(framed && sync_dir && !ss_act);
         else
            load_w = (bitn_ff == 5'h00) && !armed_ff && !smp_edge;
      end
   end

   always_ff @(posedge core_clk_i) begin
      done_ff <= 1'b0;
      if (!reset_n_i || !en_ff) begin
         st_ff        <= SPFR_IDLE;
         hcnt_ff      <= 11'h000;
         phase_ff     <= 1'b0;
         bitn_ff      <= 5'h00;
         sr_ff        <= 16'h0000;
         samp_ff      <= 1'b0;
         dout_ff      <= 1'b0;
         sck_ff       <= 1'b0;
         sync_ff      <= 1'b0;
         armed_ff     <= 1'b0;
         done_word_ff <= 16'h0000;
      end else if (!halted) begin
         if (master) begin
            case (st_ff)
               SPFR_IDLE: begin
                  sck_ff  <= clock_polarity;
                  sync_ff <= 1'b0;
                  if (load_w) begin
                     sr_ff    <= txb_ff;
                     dout_ff  <= msb_tx;
                     st_ff    <= SPFR_RUN;
                     hcnt_ff  <= 11'h000;
                     phase_ff <= 1'b0;
                     bitn_ff  <= 5'h00;
                     sck_ff   <= clock_polarity ^ ~cke_eff;
                     sync_ff  <= framed & ~sync_dir;
                  end
               end
               SPFR_RUN: begin
                  if (hcnt_ff == div_w - 11'h001) begin
                     hcnt_ff  <= 11'h000;
                     phase_ff <= ~phase_ff;
                     if (!phase_ff) begin
                        samp_ff <= sdi_s;
                        sck_ff  <= clock_polarity ^ cke_eff;
                     end else begin
                        if (data_slot) begin
                           sr_ff   <= nw_m;
                           dout_ff <= w16 ? sr_ff[14] : sr_ff[6];
                        end
                        sync_ff <= 1'b0;
                        if (last_slot) begin
                           done_ff      <= 1'b1;
                           done_word_ff <= w16 ? nw_m : {8'h00, nw_m[7:0]};
                           st_ff        <= SPFR_IDLE;
                           sck_ff       <= clock_polarity;
                        end else begin
                           bitn_ff <= bitn_ff + 5'h01;
                           sck_ff  <= clock_polarity ^ ~cke_eff;
                        end
                     end
                  end else begin
                     hcnt_ff <= hcnt_ff + 11'h001;
                  end
               end
               default: st_ff <= SPFR_IDLE;
            endcase
         end else begin
            st_ff   <= SPFR_IDLE;
            sck_ff  <= clock_polarity;
            sync_ff <= (bitn_ff == 5'h00) && !armed_ff;
            if (desel) begin
               bitn_ff  <= 5'h00;
               armed_ff <= 1'b0;
            end else begin
               if (load_w) begin
                  sr_ff   <= txb_ff;
                  dout_ff <= msb_tx;
               end else if (chg_edge) begin
                  dout_ff <= msb_sr;
               end
               if (smp_edge) begin
                  if (framed && sync_dir && !armed_ff && !ss_act) begin
                     armed_ff <= 1'b0;
                  end else if (framed && sync_dir && !armed_ff && !sync_edge) begin
                     armed_ff <= 1'b1;
                  end else begin
                     sr_ff    <= nw_s;
                     armed_ff <= framed & sync_dir;
                     if (bitn_ff == width - 5'h01) begin
                        done_ff      <= 1'b1;
                        done_word_ff <= w16 ? nw_s : {8'h00, nw_s[7:0]};
                        bitn_ff      <= 5'h00;
                        armed_ff     <= 1'b0;
                     end else begin
                        bitn_ff <= bitn_ff + 5'h01;
                     end
                  end
               end
            end
         end
      end
   end

   //---------------------------------------------------------------
   // Control registers
   //---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         en_ff   <= STAT_RST[STAT_EN];
         sidl_ff <= STAT_RST[STAT_SIDL];
         con1_ff <= CON1_RST;
         con2_ff <= CON2_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            REG_STAT: begin
               en_ff   <= reg_wdata_i[STAT_EN];
               sidl_ff <= reg_wdata_i[STAT_SIDL];
            end
            REG_CON1: con1_ff <= reg_wdata_i & CON1_WMASK;
            REG_CON2: con2_ff <= reg_wdata_i & CON2_WMASK;
            default:  sidl_ff <= sidl_ff;
         endcase
      end
   end

   //---------------------------------------------------------------
   // Holding registers and flags
   //---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         txb_ff <= 16'h0000;
         tbf_ff <= STAT_RST[STAT_TBF];
      end else if (wr_buf) begin
         txb_ff <= reg_wdata_i;
         tbf_ff <= 1'b1;
      end else if (load_w) begin
         tbf_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         rxb_ff <= 16'h0000;
         rbf_ff <= STAT_RST[STAT_RBF];
         rov_ff <= STAT_RST[STAT_ROV];
      end else begin
         if (done_ff && (!rbf_ff || rd_buf)) begin
            rxb_ff <= done_word_ff;
            rbf_ff <= 1'b1;
         end else if (rd_buf) begin
            rbf_ff <= 1'b0;
         end
         if (done_ff && rbf_ff && !rd_buf)
            rov_ff <= 1'b1;
         else if (reg_wr_i && (reg_addr_i == REG_STAT) && !reg_wdata_i[STAT_ROV])
            rov_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            REG_STAT: rdata_ff <= {en_ff, 1'b0, sidl_ff, 6'h00, rov_ff, 4'h0,
                                   tbf_ff, rbf_ff};
            REG_CON1: rdata_ff <= con1_ff;
            REG_CON2: rdata_ff <= con2_ff;
            default:  rdata_ff <= rxb_ff;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   //---------------------------------------------------------------
   // Pin drive
   //---------------------------------------------------------------
   assign reg_rdata_o = rdata_ff;
   assign sck_o       = sck_ff;
   assign sck_oe_o    = en_ff & master & ~clk_dis;
   assign sdo_o       = dout_ff;
   assign sdo_oe_o    = en_ff & ~dout_dis & ~desel;
   assign ss_o        = sync_pol ? sync_ff : ~sync_ff;
   assign ss_oe_o     = en_ff & framed & ~sync_dir;

   //---------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------
   tx_full_set_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      wr_buf |=> tbf_ff && (txb_ff == $past(reg_wdata_i)))
      else $error("transmit full not set by buffer write");

   rx_full_clr_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (rd_buf && !done_ff) |=> !rbf_ff && (reg_rdata_o == $past(rxb_ff)))
      else $error("receive full not cleared by buffer read");

   overflow_set_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (done_ff && rbf_ff && !rd_buf) |=> rov_ff && $stable(rxb_ff))
      else $error("overflow not flagged or word not discarded");

   pins_release_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !en_ff |-> !sck_oe_o && !sdo_oe_o && !ss_oe_o)
      else $error("pin driven while port disabled");

   data_pin_off_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      dout_dis |-> !sdo_oe_o)
      else $error("data pin driven while released");

   slave_clock_in_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (!master || clk_dis) |-> !sck_oe_o)
      else $error("clock pin driven in slave or disabled mode");

   idle_clock_lvl_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (en_ff && master && !halted && st_ff == SPFR_IDLE && !load_w) |=> sck_o == $past(clock_polarity))
      else $error("idle clock level wrong");

   halt_freeze_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (en_ff && $past(en_ff) && $past(halted)) |-> $stable(bitn_ff) && $stable(sr_ff))
      else $error("engine moved while halted");

   word_len_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (master && st_ff == SPFR_RUN && phase_ff && !halted && last_slot
       && hcnt_ff == div_w - 11'h001) |=> done_ff ##1 !done_ff)
      else $error("word end not reported after last bit");
endmodule

/* testbench/spfr_peer.sv */
// Serial peripheral model on the far side of the port in master mode
`timescale 1ns/1ps
module spfr_peer (
   input  wire logic        sck_i,      // Shift clock pin
   input  wire logic        sdo_i,      // Data from port
   input  wire logic        word16_i,   // Word length select
   input  wire logic [15:0] tx_word_i,  // Word sent back
   output logic             sdi_o,      // Data to port
   output logic [15:0]      rx_word_o   // Last word received
);
   int bits;

   initial begin
      sdi_o     = 1'b0;
      rx_word_o = 16'h0000;
      bits      = 0;
   end

   //---------------------------------------------------------------
   // Launch on idle-to-active edge, first bit is the top one
   //---------------------------------------------------------------
   always @(posedge sck_i) begin
      if (bits == 0) begin
         rx_word_o = 16'h0000;
      end
      sdi_o <= tx_word_i[(word16_i ? 15 : 7) - bits];
   end

   //---------------------------------------------------------------
   // Capture on active-to-idle edge; line scrambled after frame
   //---------------------------------------------------------------
   always @(negedge sck_i) begin
      rx_word_o = {rx_word_o[14:0], sdo_i};
      bits      = bits + 1;
      if (bits == (word16_i ? 16 : 8)) begin
         bits = 0;
         sdi_o <= ~sdi_o;
      end
   end
endmodule

/* testbench/spfr_port_tb_top.sv */
// Self-checking bench for the framed serial port in master mode
`timescale 1ns/1ps
module spfr_port_tb_top;
   import spfr_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset_n, idle_mode, reg_wr, reg_rd, word16;
   logic [1:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, peer_tx, peer_rx, rd_val;
   logic        sck_o, sck_oe, sdo, sdo_oe, ss_o, ss_oe, sdi, sck_pin;
   int          error_cnt = 0;
   int          checks_done = 0;

   always #2.5 core_clk = ~core_clk;
   // Clock pin has a pull-down when nobody drives it
   assign sck_pin = (sck_oe === 1'b1) ? sck_o : 1'b0;

   spfr_port dut_u (.core_clk_i(core_clk), .reset_n_i(reset_n), .idle_mode_i(idle_mode),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .ss_i(1'b1), .ss_o(ss_o), .ss_oe_o(ss_oe));
   spfr_peer peer_u (.sck_i(sck_pin), .sdo_i(sdo), .word16_i(word16), .tx_word_i(peer_tx),
      .sdi_o(sdi), .rx_word_o(peer_rx));

   //---------------------------------------------------------------
   // Shared tasks
   //---------------------------------------------------------------
   task automatic test_done();
      $display("Counts: checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_bit(input int pos);
      logic [15:0] s;
      for (int i = 0; i < 400; i++) begin
         rd(REG_STAT, s);
         if (s[pos] === 1'b1) return;
      end
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, 16'h0001 << pos);
      test_done();
   endtask

   //---------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------
   task automatic t_regs();
      rd(REG_STAT, rd_val); chk(rd_val, STAT_RST);
      rd(REG_CON1, rd_val); chk(rd_val, CON1_RST);
      rd(REG_CON2, rd_val); chk(rd_val, CON2_RST);
      wr(REG_CON1, 16'hffff); rd(REG_CON1, rd_val); chk(rd_val, 16'h1fff);
      wr(REG_CON1, 16'h0000);
      wr(REG_CON2, 16'hfffe); rd(REG_CON2, rd_val); chk(rd_val, 16'he002);
      wr(REG_CON2, 16'h0000);
      wr(REG_STAT, 16'hffff); rd(REG_STAT, rd_val); chk(rd_val, 16'ha000);
      wr(REG_STAT, 16'h0000);
      $display("test regs done");
   endtask
   task automatic t_xfer8();
      word16  <= 1'b0;
      peer_tx <= 16'h003c;
      wr(REG_CON1, 16'h0032); // Master, 16-cycle half bit
      wr(REG_STAT, 16'h8000);
      wr(REG_BUF, 16'h12a5);
      wait_bit(STAT_RBF);
      rd(REG_BUF, rd_val); chk(rd_val, 16'h003c);
      chk(peer_rx, 16'h00a5);
      rd(REG_STAT, rd_val); chk(rd_val, 16'h8000);
      $display("test xfer8 done");
   endtask
   task automatic t_halt();
      wr(REG_STAT, 16'ha000);
      @(posedge core_clk);
      idle_mode <= 1'b1;
      wr(REG_BUF, 16'h005a);
      repeat (40) @(posedge core_clk);
      rd(REG_STAT, rd_val); chk(rd_val, 16'ha002);
      @(posedge core_clk);
      idle_mode <= 1'b0;
      wait_bit(STAT_RBF);
      rd(REG_BUF, rd_val); chk(rd_val, 16'h003c);
      chk(peer_rx, 16'h005a);
      wr(REG_STAT, 16'h8000);
      $display("test halt done");
   endtask
   task automatic t_ovf();
      wr(REG_BUF, 16'h0081);
      wr(REG_BUF, 16'h0042);
      wait_bit(STAT_ROV);
      rd(REG_STAT, rd_val); chk(rd_val, 16'h8041);
      chk(peer_rx, 16'h0042);
      rd(REG_BUF, rd_val); chk(rd_val, 16'h003c);
      wr(REG_STAT, 16'h8000);
      rd(REG_STAT, rd_val); chk(rd_val, 16'h8000);
      $display("test overflow done");
   endtask
   task automatic t_w16();
      word16  <= 1'b1;
      peer_tx <= 16'hbeef;
      wr(REG_CON1, 16'h0432);
      wr(REG_BUF, 16'h1234);
      wait_bit(STAT_RBF);
      rd(REG_BUF, rd_val); chk(rd_val, 16'hbeef);
      chk(peer_rx, 16'h1234);
      $display("test word16 done");
   endtask
   task automatic t_smp();
      word16  <= 1'b0;
      peer_tx <= 16'h003c;
      wr(REG_CON1, 16'h0232); // End-of-bit sampling
      wr(REG_BUF, 16'h00c3);
      wait_bit(STAT_RBF);
      rd(REG_BUF, rd_val); chk(rd_val, 16'h003d);
      chk(peer_rx, 16'h00c3);
      $display("test sample end done");
   endtask
   task automatic t_pins();
      wr(REG_CON1, 16'h0032);
      repeat (2) @(posedge core_clk);
      chk({14'h0, sck_oe, sdo_oe}, 16'h0003);
      wr(REG_CON1, 16'h1032); @(posedge core_clk); chk({15'h0, sck_oe}, 16'h0000);
      wr(REG_CON1, 16'h0832); @(posedge core_clk); chk({15'h0, sdo_oe}, 16'h0000);
      wr(REG_CON2, 16'h8000); @(posedge core_clk);
      chk({14'h0, ss_oe, ss_o}, 16'h0003);
      wr(REG_CON2, 16'hc000); @(posedge core_clk); chk({15'h0, ss_oe}, 16'h0000);
      wr(REG_CON2, 16'h0000);
      wr(REG_CON1, 16'h0072);
      repeat (4) @(posedge core_clk);
      chk({15'h0, sck_o}, 16'h0001);
      wr(REG_STAT, 16'h0000); @(posedge core_clk);
      chk({14'h0, sck_oe, sdo_oe}, 16'h0000);
      $display("test pins done");
   endtask

   initial begin
      reset_n   = 1'b0;
      idle_mode = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 2'h0;
      reg_wdata = 16'h0000;
      word16    = 1'b0;
      peer_tx   = 16'h0000;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      t_regs();
      t_xfer8();
      t_halt();
      t_ovf();
      t_w16();
      t_smp();
      t_pins();
      test_done();
   end
endmodule
